// ===== design/adbp_decode.sv
// address decoder, peripheral access sequencer and memory block protection
// Functional notes
// RULE1: peripheral accesses are timed by the divided peripheral clock
// RULE2: byte, halfword and word accesses pass to any peripheral
// RULE3: location register routes each peripheral on-chip or off-chip
// RULE4: protection register restricts each peripheral in user mode
// RULE5: peripherals held in reset until release bit 0 set
// RULE6: peripheral clock divides system clock by bits 4:1 setting
// RULE7: peripheral logic never relies on a balanced duty cycle
// RULE8: peripheral reads last at least two peripheral clock periods
// RULE9: peripheral writes last two peripheral periods plus one system cycle
// RULE10: wait states align access start to a peripheral clock boundary
// RULE11: frame range decode drives peripheral select with low 10 bits
// RULE12: each peripheral owns one 1 KB register frame
// RULE13: addresses 0x00 to 0x1F always decode valid
// RULE14: after reset boot memory on select 0 mirrors through lower 2 GB
// RULE15: selects compare base against address with n low bits masked
// RULE16: software puts each base on a multiple of its block size
// RULE17: at reset only memory select 0 is enabled
// RULE18: map enable bit 8 switches selects to programmed bases
// RULE19: boot code configures all selects before enabling the map
// RULE20: boot code branches into relocated image before switching map
// RULE21: software keeps memory out of the top 2 MB
// RULE22: block protection applies privileged-only bit 0 and read-only bit 1
// RULE23: block protection evaluated apart from the auxiliary protection unit
// RULE24: protection violation raises illegal access and blocks the write
// RULE25: user access to protected peripheral gets no peripheral select
// RULE26: user violation aborts, privileged violation requests reset
// RULE27: divide ratio is divider field plus one
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module adbp_decode (
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    // register port
    input  wire logic [7:0]             regAddr,
    input  wire logic [31:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [31:0]            regRdata,
    // cpu request port
    input  wire logic                   cpuReq,
    input  wire logic [31:0]            cpuAddr,
    input  wire logic                   cpuWrite,
    input  wire logic [1:0]             cpuSize,
    input  wire logic                   cpuUser,
    input  wire logic [31:0]            cpuWdata,
    output logic                        cpuBusy,
    output logic                        cpuDone,
    output logic      [31:0]            cpuRdata,
    output logic                        illegalAccess,
    output logic                        periphIllegal,
    output logic                        abortReq,
    output logic                        resetReq,
    output logic                        blockDeny,
    output logic                        vectorValid,
    // peripheral side
    output logic                        periphTick,
    output logic                        periphResetN,
    output logic [adbp_pkg::NUM_PERIPH-1:0] periphSel,
    output logic                        periphOffChip,
    output logic      [9:0]             periphAddr,
    output logic                        periphWr,
    output logic                        periphRd,
    output logic      [1:0]             periphSize,
    output logic      [31:0]            periphWdata,
    input  wire logic [31:0]            periphRdata,
    // memory side
    output logic [adbp_pkg::NUM_MEM-1:0] memSel,
    output logic      [31:0]            memAddr,
    output logic                        memWr,
    output logic                        memRd,
    output logic      [1:0]             memSize,
    output logic      [31:0]            memWdata,
    input  wire logic [31:0]            memRdata
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEC,
        ST_MEM,
        ST_PALIGN,
        ST_PACC,
        ST_PWHOLD,
        ST_DONE
    } adbp_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [31:0] pclkCtrl_r;
    logic [15:0] ploc_r;
    logic [15:0] pprot_r;
    logic [15:0] baseHi_r  [adbp_pkg::NUM_MEM];
    logic [31:0] baseLo_r  [adbp_pkg::NUM_MEM];
    logic [31:0] rdMux;
    logic [31:0] memRdMux  [adbp_pkg::NUM_MEM+1];

    wire         wrPclk  = regWr && (regAddr == adbp_pkg::PCLK_CTRL_OFS);
    wire         wrPloc  = regWr && (regAddr == adbp_pkg::PLOC_OFS);
    wire         wrPprot = regWr && (regAddr == adbp_pkg::PPROT_OFS);
    wire [3:0]   divSet  = pclkCtrl_r[adbp_pkg::PCLK_DIV_MSB:adbp_pkg::PCLK_DIV_LSB];
    wire         released = pclkCtrl_r[adbp_pkg::PCLK_RELEASE_BIT];
    wire         mapEn   = baseLo_r[0][adbp_pkg::MAP_EN_BIT];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pclkCtrl_r <= adbp_pkg::PCLK_CTRL_RST;
            ploc_r     <= adbp_pkg::PLOC_RST;
            pprot_r    <= adbp_pkg::PPROT_RST;
        end else begin
            if (wrPclk) begin
                pclkCtrl_r <= {27'h0000000, regWdata[adbp_pkg::PCLK_DIV_MSB:0]};
            end
            if (wrPloc) begin
                ploc_r <= regWdata[15:0];
            end
            if (wrPprot) begin
                pprot_r <= regWdata[15:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < adbp_pkg::NUM_MEM; gi++) begin : g_memreg
            localparam logic [7:0] HI_OFS = 8'(adbp_pkg::MEM_BASE_OFS
                                             + adbp_pkg::MEM_STRIDE * gi);
            localparam logic [7:0] LO_OFS = 8'(HI_OFS + adbp_pkg::MEM_LOW_OFS);
            localparam logic [3:0] SZ_RST = (gi == 0) ? adbp_pkg::BOOT_SIZE_RST
                                                      : adbp_pkg::SIZE_RST;
            wire wrHi = regWr && (regAddr == HI_OFS);
            wire wrLo = regWr && (regAddr == LO_OFS);
            wire [31:0] loKeep = (gi == 0) ? 32'hFC00_01F3 : 32'hFC00_00F3;
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    baseHi_r[gi] <= adbp_pkg::BASE_HI_RST;
                    baseLo_r[gi] <= {24'h000000, SZ_RST, 4'h0};
                end else begin
                    if (wrHi) begin
                        baseHi_r[gi] <= regWdata[15:0];
                    end
                    if (wrLo) begin
                        baseLo_r[gi] <= regWdata & loKeep;
                    end
                end
            end
            assign memRdMux[gi+1] = (regAddr == HI_OFS) ? {16'h0000, baseHi_r[gi]} :
                                    (regAddr == LO_OFS) ? baseLo_r[gi] : memRdMux[gi];
        end
    endgenerate

    assign memRdMux[0] = 32'h0000_0000;
    assign rdMux = (regAddr == adbp_pkg::PCLK_CTRL_OFS) ? pclkCtrl_r :
                   (regAddr == adbp_pkg::PLOC_OFS)      ? {16'h0000, ploc_r} :
                   (regAddr == adbp_pkg::PPROT_OFS)     ? {16'h0000, pprot_r} :
                   memRdMux[adbp_pkg::NUM_MEM];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= regRd ? rdMux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral clock divider

    logic [3:0] divCnt_r;
    logic [3:0] divCnt_nxt;
    logic       prst_r;

    // tick marks the last system cycle of each peripheral clock period
    assign periphTick = (divCnt_r >= divSet);                   // RULE27
    assign divCnt_nxt = periphTick ? 4'h0 : divCnt_r + 4'h1;    // RULE6

    // a single strobe per period, so the high and low split never matters
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_r <= 4'h0;
        end else begin
            divCnt_r <= divCnt_nxt;                              // RULE7
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prst_r <= 1'b0;
        end else begin
            prst_r <= released;                                  // RULE5
        end
    end
    assign periphResetN = prst_r;

    ////////////////////////////////////////////////////////////////////////////
    // request capture and decode

    adbp_state_t state_r;
    adbp_state_t state_nxt;
    logic [31:0] reqAddr_r;
    logic        reqWrite_r;
    logic [1:0]  reqSize_r;
    logic        reqUser_r;
    logic [31:0] reqWdata_r;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reqAddr_r  <= 32'h0000_0000;
            reqWrite_r <= 1'b0;
            reqSize_r  <= adbp_pkg::SZ_BYTE;
            reqUser_r  <= 1'b0;
            reqWdata_r <= 32'h0000_0000;
        end else if (state_r == ST_IDLE && cpuReq) begin
            reqAddr_r  <= cpuAddr;
            reqWrite_r <= cpuWrite;
            reqSize_r  <= cpuSize;                               // RULE2
            reqUser_r  <= cpuUser;
            reqWdata_r <= cpuWdata;
        end
    end

    wire        inFrame  = (reqAddr_r[31:14] == adbp_pkg::PFRAME_TAG);  // RULE11
    wire [3:0]  frameIdx = reqAddr_r[13:10];                            // RULE12
    wire        pDenied  = reqUser_r && pprot_r[frameIdx];              // RULE4
    wire        pBlocked = pDenied || !prst_r;                          // RULE5
    wire        isVector = (reqAddr_r[31:5] == adbp_pkg::VECTOR_TAG);  // RULE13

    logic [adbp_pkg::NUM_MEM-1:0] hit;
    logic [21:0] sizeMask [adbp_pkg::NUM_MEM];

    generate
        for (gi = 0; gi < adbp_pkg::NUM_MEM; gi++) begin : g_match
            wire [3:0]  sz     = baseLo_r[gi][adbp_pkg::SIZE_MSB:adbp_pkg::SIZE_LSB];
            wire [21:0] base22 = {baseHi_r[gi],
                                  baseLo_r[gi][adbp_pkg::BASE_LO_MSB:adbp_pkg::BASE_LO_LSB]};
            assign sizeMask[gi] = adbp_pkg::FULL_MASK << sz;
            wire match = ((reqAddr_r[31:10] & sizeMask[gi])
                          == (base22 & sizeMask[gi]));           // RULE15
            if (gi == 0) begin : g_boot
                assign hit[gi] = mapEn ? match : !reqAddr_r[31];         // RULE14
            end else begin : g_rest
                assign hit[gi] = mapEn && match && !inFrame;             // RULE17 RULE18
            end
        end
    endgenerate

    // lowest select wins where regions overlap
    logic [adbp_pkg::NUM_MEM-1:0] selOne;
    logic [adbp_pkg::NUM_MEM-1:0] hitBefore;
    logic [2:0]                   selIdx [adbp_pkg::NUM_MEM+1];
    generate
        for (gi = 0; gi < adbp_pkg::NUM_MEM; gi++) begin : g_prio
            if (gi == 0) begin : g_first
                assign hitBefore[gi] = 1'b0;
            end else begin : g_next
                assign hitBefore[gi] = hitBefore[gi-1] | hit[gi-1];
            end
            assign selOne[gi] = hit[gi] && !hitBefore[gi];
            assign selIdx[gi+1] = selOne[gi] ? 3'(gi) : selIdx[gi];
        end
    endgenerate
    assign selIdx[0] = 3'h0;

    wire         memHit   = |hit && !inFrame;
    wire [2:0]   hitIdx   = selIdx[adbp_pkg::NUM_MEM];
    wire         privFlag = baseLo_r[hitIdx][adbp_pkg::PRIVILEGED_ONLY_FLAG_BIT];
    wire         roFlag   = baseLo_r[hitIdx][adbp_pkg::WRITE_PROTECT_FLAG_BIT];
    // block check only; the auxiliary unit grants on its own path
    wire         memViol  = memHit && ((privFlag && reqUser_r)
                                       || (roFlag && reqWrite_r));  // RULE22 RULE23
    wire [31:0]  lowMask  = {~sizeMask[hitIdx], adbp_pkg::FRAME_LOW};

    ////////////////////////////////////////////////////////////////////////////
    // access sequencer

    logic [1:0] tickCnt_r;
    wire        lastTick = periphTick && (tickCnt_r == adbp_pkg::PACC_PERIODS - 2'h1);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (cpuReq) begin
                    state_nxt = ST_DEC;
                end
            end
            ST_DEC: begin
                if (inFrame && !pBlocked) begin
                    state_nxt = ST_PALIGN;
                end else if (!inFrame && memHit) begin
                    state_nxt = ST_MEM;
                end else begin
                    state_nxt = ST_DONE;
                end
            end
            ST_MEM: begin
                state_nxt = ST_DONE;
            end
            ST_PALIGN: begin
                if (periphTick) begin
                    state_nxt = ST_PACC;                         // RULE10
                end
            end
            ST_PACC: begin
                if (lastTick) begin
                    state_nxt = reqWrite_r ? ST_PWHOLD : ST_DONE; // RULE8 RULE9
                end
            end
            ST_PWHOLD: begin
                state_nxt = ST_DONE;                             // RULE9
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tickCnt_r <= 2'h0;
        end else if (state_r != ST_PACC) begin
            tickCnt_r <= 2'h0;
        end else if (periphTick) begin
            tickCnt_r <= tickCnt_r + 2'h1;                       // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral outputs

    wire startPacc = (state_r == ST_PALIGN) && periphTick;
    wire endPacc   = ((state_r == ST_PACC) && lastTick && !reqWrite_r)
                     || (state_r == ST_PWHOLD);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            periphSel <= '0;
            periphWr <= 1'b0;
            periphRd <= 1'b0;
            periphOffChip <= 1'b0;
            periphAddr <= 10'h000;
        end else if (startPacc) begin
            periphSel <= 16'(1) << frameIdx; // RULE11 RULE25
            periphWr <= reqWrite_r;
            periphRd <= !reqWrite_r;
            periphOffChip <= ploc_r[frameIdx]; // RULE3
            periphAddr <= reqAddr_r[9:0]; // RULE11
        end else if (endPacc) begin
            periphSel <= '0;
            periphWr <= 1'b0;
            periphRd <= 1'b0;
        end
    end

    assign periphSize    = reqSize_r;
    assign periphWdata   = reqWdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // memory outputs

    wire         goMem = (state_r == ST_DEC) && !inFrame && memHit;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            memSel <= '0;
            memWr <= 1'b0;
            memRd <= 1'b0;
            memAddr <= 32'h0000_0000;
        end else if (goMem) begin
            memSel <= selOne;
            memWr <= reqWrite_r && !memViol; // RULE24
            memRd <= !reqWrite_r;
            memAddr <= reqAddr_r & lowMask; // RULE15
        end else begin
            memSel <= '0;
            memWr <= 1'b0;
            memRd <= 1'b0;
        end
    end

    assign memSize  = reqSize_r;
    assign memWdata = reqWdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // completion and exceptions

    wire         decStep = (state_r == ST_DEC);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cpuRdata <= 32'h0000_0000;
        end else if (decStep) begin
            cpuRdata <= 32'h0000_0000;
        end else if (state_r == ST_MEM && !reqWrite_r) begin
            cpuRdata <= memRdata;
        end else if (state_r == ST_PACC && lastTick && !reqWrite_r) begin
            cpuRdata <= periphRdata; // RULE8
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            illegalAccess <= 1'b0;
            periphIllegal <= 1'b0;
            abortReq <= 1'b0;
            resetReq <= 1'b0;
            blockDeny <= 1'b0;
            vectorValid <= 1'b0;
        end else begin
            illegalAccess <= decStep && memViol; // RULE24
            periphIllegal <= decStep && inFrame && pDenied; // RULE25
            abortReq <= decStep && reqUser_r && (memViol || (inFrame && pDenied)); // RULE26
            resetReq <= decStep && !reqUser_r && memViol; // RULE26
            blockDeny <= decStep && memViol; // RULE23
            vectorValid <= decStep && isVector; // RULE13
        end
    end

    assign cpuDone       = (state_r == ST_DONE);
    assign cpuBusy       = (state_r != ST_IDLE);

endmodule

// ===== design/adbp_pkg.sv
// constants for the address decoder and block protection unit
package adbp_pkg;

    // register word offsets on the register port (byte addresses)
    localparam logic [7:0] PCLK_CTRL_OFS  = 8'h00;
    localparam logic [7:0] PLOC_OFS       = 8'h04;
    localparam logic [7:0] PPROT_OFS      = 8'h08;
    localparam logic [7:0] MEM_BASE_OFS   = 8'h10;
    localparam logic [7:0] MEM_STRIDE     = 8'h08;
    localparam logic [7:0] MEM_LOW_OFS    = 8'h04;

    // counts
    localparam int NUM_PERIPH = 16;
    localparam int NUM_MEM    = 6;
    localparam int NUM_FIXED  = 4;

    // peripheral clock control fields
    localparam int PCLK_RELEASE_BIT = 0;
    localparam int PCLK_DIV_LSB     = 1;
    localparam int PCLK_DIV_MSB     = 4;

    // memory base low fields
    localparam int PRIVILEGED_ONLY_FLAG_BIT       = 0;
    localparam int WRITE_PROTECT_FLAG_BIT      = 1;
    localparam int SIZE_LSB       = 4;
    localparam int SIZE_MSB       = 7;
    localparam int MAP_EN_BIT     = 8;
    localparam int BASE_LO_LSB    = 26;
    localparam int BASE_LO_MSB    = 31;

    // reset values
    localparam logic [31:0] PCLK_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] PLOC_RST      = 16'h0000;
    localparam logic [15:0] PPROT_RST     = 16'h0000;
    localparam logic [15:0] BASE_HI_RST   = 16'h0000;
    localparam logic [3:0]  BOOT_SIZE_RST = 4'h6;
    localparam logic [3:0]  SIZE_RST      = 4'h0;

    // address decode
    localparam logic [17:0] PFRAME_TAG    = 18'h3FFDF;
    localparam logic [21:0] FULL_MASK     = 22'h3FFFFF;
    localparam logic [9:0]  FRAME_LOW     = 10'h3FF;
    localparam logic [26:0] VECTOR_TAG    = 27'h0000000;

    // peripheral access length in peripheral clock periods
    localparam logic [1:0]  PACC_PERIODS  = 2'h2;

    // access sizes
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } adbp_size_t;

endpackage

// ===== sim/adbp_decode_asserts.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module adbp_decode_asserts (
    input wire logic                          core_clk,
    input wire logic                          nrst,
    input wire logic                          cpuReq,
    input wire logic                          cpuBusy,
    input wire logic [31:0]                   cpuAddr,
    input wire logic                          periphTick,
    input wire logic                          periphResetN,
    input wire logic [adbp_pkg::NUM_PERIPH-1:0] periphSel,
    input wire logic                          periphWr,
    input wire logic                          periphRd,
    input wire logic [adbp_pkg::NUM_MEM-1:0]  memSel,
    input wire logic                          memWr,
    input wire logic                          memRd,
    input wire logic                          illegalAccess,
    input wire logic                          periphIllegal,
    input wire logic                          abortReq,
    input wire logic                          resetReq,
    input wire logic                          blockDeny,
    input wire logic                          vectorValid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] accTicks_r;
    // ticks seen while a peripheral is selected
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) accTicks_r <= 8'h00;
        else if (|periphSel) accTicks_r <= accTicks_r + {7'h00, periphTick};
        else accTicks_r <= 8'h00;
    end
    sequence vecReq;
        cpuReq && !cpuBusy && cpuAddr[31:5] == 27'h0000000;
    endsequence
    sequence noSel;
        periphSel == '0;
    endsequence
    AST_MEMSEL_ONEHOT: assert property ($onehot0(memSel)) else $error("memory select not one-hot");
    AST_PSEL_ONEHOT: assert property ($onehot0(periphSel)) else $error("periph select not one-hot");
    AST_PSEL_RELEASE: assert property (!periphResetN |-> noSel) else $error("select in reset");
    AST_PSEL_STROBE: assert property (|periphSel |-> periphRd ^ periphWr) else $error("no strobe");
    AST_PACC_LEN: assert property ($fell(|periphSel) |-> accTicks_r >= 8'h02) else $error("short access");
    AST_PACC_ALIGN: assert property ($rose(|periphSel) |-> $past(periphTick)) else $error("unaligned");
    AST_WR_BLOCK: assert property (illegalAccess |-> !memWr) else $error("write not blocked");
    AST_DENY_SAME: assert property (blockDeny == illegalAccess) else $error("deny mismatch");
    AST_PRIVILEGED_ONLY_FLAG_RESET: assert property (resetReq |-> illegalAccess && !abortReq) else $error("bad reset");
    AST_PILL_NOSEL: assert property (periphIllegal |-> abortReq ##0 noSel ##1 noSel) else $error("sel");
    AST_VECTOR: assert property (vecReq |-> ##2 vectorValid) else $error("vector not valid");
    AST_MEMSEL_STROBE: assert property (|memSel |-> memRd || memWr || illegalAccess) else $error("idle");
endmodule
bind adbp_decode adbp_decode_asserts u_chk (.*);

// ===== sim/adbp_decode_tb.sv
// self-checking bench for the address decoder and block protection unit
`timescale 1ns/1ps
module adbp_decode_tb;
    logic core_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, cpuAddr = 32'h0, cpuWdata = 32'h0, rd;
    logic cpuReq = 1'b0, cpuWrite = 1'b0, cpuUser = 1'b0;
    logic [1:0] cpuSize = 2'h2;
    logic [31:0] regRdata, cpuRdata, memAddr, memWdata, periphWdata, periphRdata, memRdata;
    logic cpuBusy, cpuDone, illegalAccess, periphIllegal, abortReq, resetReq, blockDeny;
    logic vectorValid, periphTick, periphResetN, periphOffChip, periphWr, periphRd, memWr, memRd;
    logic [adbp_pkg::NUM_PERIPH-1:0] periphSel, pSeen;
    logic [adbp_pkg::NUM_MEM-1:0] memSel, mSeen;
    logic [9:0] periphAddr;
    logic [1:0] periphSize, memSize;
    logic [6:0] fl;
    int failures = 0, tests_run = 0, n;
    adbp_decode DUT (.*);
    adbp_far_model u_far (.*);
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk("regRdata", e, regRdata);
    endtask
    // one cpu access; flags: illegal abort reset pIllegal vector offChip memWr
    task automatic cpuAcc(input logic [31:0] a, input logic w, input logic u, input logic [1:0] s);
        int k = 0;
        mSeen = '0;
        pSeen = '0;
        fl = 7'h00;
        @(posedge core_clk);
        cpuReq <= 1'b1;
        cpuAddr <= a;
        cpuWrite <= w;
        cpuUser <= u;
        cpuSize <= s;
        cpuWdata <= ~a;
        @(posedge core_clk);
        cpuReq <= 1'b0;
        #1;
        forever begin
            mSeen |= memSel;
            pSeen |= periphSel;
            fl |= {illegalAccess, abortReq, resetReq, periphIllegal, vectorValid, periphOffChip, memWr};
            if (cpuDone || k > 60) break;
            @(posedge core_clk);
            #1;
            k++;
        end
        chk("cpuDone", 32'h1, {31'h0, cpuDone});
        rd = cpuRdata;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        rdReg(8'h00, 32'h0);
        rdReg(8'h14, 32'h60);
        rdReg(8'h1C, 32'h0);
        rdReg(8'hFC, 32'h0);
        cpuAcc(32'h0001_2340, 1'b0, 1'b0, adbp_pkg::SZ_WORD);
        chk("bootSel", 32'h1, 32'(mSeen));
        chk("bootData", 32'h5A00_2340, rd);
        cpuAcc(32'h8000_0040, 1'b0, 1'b0, adbp_pkg::SZ_WORD);
        chk("highSel", 32'h0, 32'(mSeen));
        cpuAcc(32'h0000_0010, 1'b0, 1'b0, adbp_pkg::SZ_WORD);
        chk("vector", 32'h4, 32'(fl & 7'h04));
        cpuAcc(32'hFFF7_C804, 1'b0, 1'b0, adbp_pkg::SZ_WORD);
        chk("held", 32'h0, 32'(pSeen));
        wrReg(8'h00, 32'h5);
        wrReg(8'h04, 32'h4);
        do @(posedge core_clk); while (!periphTick);
        n = 0;
        do begin @(posedge core_clk); n++; end while (!periphTick && n < 20);
        chk("tickGap", 32'h3, 32'(n));
        cpuAcc(32'hFFF7_C804, 1'b0, 1'b0, adbp_pkg::SZ_BYTE);
        chk("pSel", 32'h4, 32'(pSeen));
        chk("pData", 32'hC300_0004, rd);
        chk("offChip", 32'h2, 32'(fl & 7'h02));
        cpuAcc(32'hFFF7_C804, 1'b1, 1'b0, adbp_pkg::SZ_HALF);
        chk("pWrSel", 32'h4, 32'(pSeen));
        chk("pSize", 32'h1, 32'(periphSize));
        wrReg(8'h08, 32'h4);
        cpuAcc(32'hFFF7_C804, 1'b0, 1'b1, adbp_pkg::SZ_WORD);
        chk("pProt", 32'h0, 32'(pSeen));
        chk("pAbort", 32'h28, 32'(fl & 7'h28));
        wrReg(8'h18, 32'h0010);
        wrReg(8'h1C, 32'h3);
        wrReg(8'h14, 32'h160);
        cpuAcc(32'h0010_0004, 1'b1, 1'b1, adbp_pkg::SZ_WORD);
        chk("userWr", 32'h60, 32'(fl & 7'h71));
        cpuAcc(32'h0010_0004, 1'b1, 1'b0, adbp_pkg::SZ_WORD);
        chk("privWr", 32'h50, 32'(fl & 7'h71));
        cpuAcc(32'h0010_0004, 1'b0, 1'b0, adbp_pkg::SZ_WORD);
        chk("privRd", 32'h2, 32'(mSeen));
        chk("privData", 32'h5A00_0004, rd);
        cpuAcc(32'h0002_0000, 1'b0, 1'b0, adbp_pkg::SZ_WORD);
        chk("noMirror", 32'h0, 32'(mSeen));
        end_sim();
    end
endmodule

// ===== sim/adbp_far_model.sv
// far side model: memory and peripherals answering reads with address-derived data
`timescale 1ns/1ps
module adbp_far_model (
    input  wire logic                            core_clk,
    input  wire logic                            nrst,
    input  wire logic [adbp_pkg::NUM_PERIPH-1:0] periphSel,
    input  wire logic [9:0]                      periphAddr,
    input  wire logic [adbp_pkg::NUM_MEM-1:0]    memSel,
    input  wire logic [31:0]                     memAddr,
    output logic      [31:0]                     periphRdata,
    output logic      [31:0]                     memRdata
);
    logic [31:0] pLast_r;
    logic [31:0] mLast_r;
    // unselected data lines toggle every cycle
    assign periphRdata = |periphSel ? {22'h000000, periphAddr} ^ 32'hC300_0000 : ~pLast_r;
    assign memRdata    = |memSel ? memAddr ^ 32'h5A00_0000 : ~mLast_r;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) pLast_r <= 32'h0000_0000;
        else pLast_r <= periphRdata;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) mLast_r <= 32'h0000_0000;
        else mLast_r <= memRdata;
    end
endmodule
